// ### design/reset_ctl_pkg.sv
// Constants and carrier types for the reset control unit
// Operation
// - Cold reset comes from supply detector or from standby exit generator.
// - Cold reset returns all non-backup registers to their default values.
// - Cold reset held low until core regulator reports its rail ready.
// - Cold, pin, both watchdogs, soft request, option loader raise system reset.
// - Standby entry raises system reset when its option bit is cleared.
// - Deep-sleep entry raises system reset when its option bit is cleared.
// - Low voltage, crystal, PLL, stall, ECC resets only when enabled.
// - System reset hits core and peripherals, spares debug port and backup.
// - Every system reset source gives a low pulse of at least 20 us.
// - Backup domain reset from software bit or backup supply power on.
package reset_ctl_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 50000000;
    localparam int unsigned SYS_PULSE_NS = 20000;
    // Least time, rounded up to whole cycles
    localparam int unsigned SYS_PULSE_CYCLES = (SYS_PULSE_NS * (CLK_FREQ_HZ / 1000000) + 999) / 1000;
    localparam int unsigned PULSE_CNT_W = 11;
    localparam logic [PULSE_CNT_W-1:0] PULSE_CNT_RESET = 11'h000;

    // ----------------------------------------
    // Carrier types
    // ----------------------------------------
    // Active-low reset requests from peripherals (all synchronised inside)
    typedef struct packed {
        logic window_dog_reset_n;
        logic free_dog_reset_n;
        logic soft_reset_n;
        logic option_loader_reset_n;
        logic low_volt_reset_n;
        logic crystal_loss_reset_n;
        logic pll_loss_reset_n;
        logic cpu_stall_reset_n;
        logic ecc_fault_reset_n;
    } reset_req_t;

    // Enable bits of the reset source/clock register
    typedef struct packed {
        logic low_volt_reset_en;
        logic crystal_loss_reset_en;
        logic pll_loss_reset_en;
        logic cpu_stall_reset_en;
        logic ecc_fault_reset_en;
    } reset_en_t;

    localparam int unsigned REQ_W = $bits(reset_req_t);
endpackage

// ### design/sync2.sv
// Two flip-flop level synchroniser with a constant reset value
`timescale 1ns/10ps
module sync2 #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta_r;
    logic meta_nxt;
    logic q_nxt;

    // Next values: first stage only feeds the second
    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    // Registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_r <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_r <= meta_nxt;
            q <= q_nxt;
        end
    end
endmodule

// ### design/pulse_stretch.sv
// Stretches a reset request into a minimum-length active-high pulse
`timescale 1ns/10ps
module pulse_stretch
    import reset_ctl_pkg::*;
#(
    parameter int unsigned CYCLES = SYS_PULSE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic trigger,
    output logic active
);
    logic [PULSE_CNT_W-1:0] cnt_r;
    logic [PULSE_CNT_W-1:0] cnt_nxt;

    // Reload while trigger stands, then count down the full stretch
    always_comb begin
        cnt_nxt = cnt_r;
        if (trigger) begin
            cnt_nxt = PULSE_CNT_W'(CYCLES);
        end else if (cnt_r != PULSE_CNT_RESET) begin
            cnt_nxt = cnt_r - PULSE_CNT_W'(1);
        end
    end

    // Reset loads full count so the pulse after reset is full length too
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= PULSE_CNT_W'(CYCLES);
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign active = trigger || (cnt_r != PULSE_CNT_RESET);
endmodule

// ### design/reset_control_unit.sv
// Reset control unit: cold, system and backup domain reset generation
`timescale 1ns/10ps
module reset_control_unit
    import reset_ctl_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = SYS_PULSE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic supply_up_down_detect,
    input wire logic standby_exit,
    input wire logic regulator_ready,
    input wire logic ext_reset_pin_n,
    input wire reset_req_t reset_req,
    input wire reset_en_t reset_en,
    input wire logic standby_entry,
    input wire logic deepsleep_entry,
    input wire logic standby_entry_reset_opt,
    input wire logic deepsleep_entry_reset_opt,
    input wire logic backup_domain_reset_bit,
    input wire logic backup_supply_power_on,
    output logic cold_reset_n,
    output logic sys_reset_n,
    output logic core_reset_n,
    output logic periph_reset_n,
    output logic debug_port_reset_n,
    output logic backup_reset_n,
    output logic standby_entry_reset_n,
    output logic deepsleep_entry_reset_n
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    localparam int unsigned NSYNC = REQ_W + 10;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync_in;

    assign raw_in = {reset_req, ext_reset_pin_n, supply_up_down_detect, standby_exit,
                     regulator_ready, standby_entry, deepsleep_entry, standby_entry_reset_opt,
                     deepsleep_entry_reset_opt, backup_domain_reset_bit, backup_supply_power_on};
    // Requests idle high, events and flags idle low; options idle high (no reset)
    // A constant, since each synchroniser takes its reset value as a parameter
    localparam logic [NSYNC-1:0] SYNC_RST_VAL = {{(REQ_W + 1){1'b1}}, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                                                 1'b1, 1'b1, 1'b0, 1'b0};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            sync2 #(
                .RESET_VAL(SYNC_RST_VAL[gi])
            ) u_sync (
                .ref_clk(ref_clk),
                .rst(rst),
                .d(raw_in[gi]),
                .q(sync_in[gi])
            );
        end
    endgenerate

    reset_req_t req_s;
    logic pin_n_s;
    logic por_s;
    logic stby_exit_s;
    logic ldo_ok_s;
    logic stby_in_s;
    logic dslp_in_s;
    logic stby_opt_s;
    logic dslp_opt_s;
    logic bkp_bit_s;
    logic bkp_pon_s;

    assign {req_s, pin_n_s, por_s, stby_exit_s, ldo_ok_s, stby_in_s, dslp_in_s, stby_opt_s,
            dslp_opt_s, bkp_bit_s, bkp_pon_s} = sync_in;

    // ----------------------------------------
    // Cold reset
    // ----------------------------------------
    logic cold_hold_r;
    logic cold_hold_nxt;
    logic cold_n_r;
    logic cold_n_nxt;

    // Cold reset sources
    // Hold latches a cold event until the regulator confirms its rail.
    always_comb begin
        cold_hold_nxt = cold_hold_r;
        if (por_s || stby_exit_s) begin
            cold_hold_nxt = 1'b1;
        end else if (ldo_ok_s) begin
            cold_hold_nxt = 1'b0;
        end
        cold_n_nxt = !cold_hold_nxt && ldo_ok_s;
    end

    // Asserted from reset onward; cold reset covers everything but backup domain
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cold_hold_r <= 1'b1;
            cold_n_r <= 1'b0;
        end else begin
            cold_hold_r <= cold_hold_nxt;
            cold_n_r <= cold_n_nxt;
        end
    end

    assign cold_reset_n = cold_n_r;

    // ----------------------------------------
    // Option-byte entry resets
    // ----------------------------------------
    logic stby_rst_n_r;
    logic stby_rst_n_nxt;
    logic dslp_rst_n_r;
    logic dslp_rst_n_nxt;

    always_comb begin
        stby_rst_n_nxt = !(stby_in_s && !stby_opt_s);
        dslp_rst_n_nxt = !(dslp_in_s && !dslp_opt_s);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stby_rst_n_r <= 1'b1;
            dslp_rst_n_r <= 1'b1;
        end else begin
            stby_rst_n_r <= stby_rst_n_nxt;
            dslp_rst_n_r <= dslp_rst_n_nxt;
        end
    end

    assign standby_entry_reset_n = stby_rst_n_r;
    assign deepsleep_entry_reset_n = dslp_rst_n_r;

    // ----------------------------------------
    // System reset source collection
    // ----------------------------------------
    logic fixed_src;
    logic cond_src;
    logic any_src;

    always_comb begin
        fixed_src = !cold_n_r || !pin_n_s || !req_s.window_dog_reset_n || !req_s.free_dog_reset_n
                    || !req_s.soft_reset_n || !req_s.option_loader_reset_n
                    || !stby_rst_n_r || !dslp_rst_n_r;
        cond_src = (reset_en.low_volt_reset_en && !req_s.low_volt_reset_n)
                   || (reset_en.crystal_loss_reset_en && !req_s.crystal_loss_reset_n)
                   || (reset_en.pll_loss_reset_en && !req_s.pll_loss_reset_n)
                   || (reset_en.cpu_stall_reset_en && !req_s.cpu_stall_reset_n)
                   || (reset_en.ecc_fault_reset_en && !req_s.ecc_fault_reset_n);
        any_src = fixed_src || cond_src;
    end

    // ----------------------------------------
    // Pulse stretch and synchronous release
    // ----------------------------------------
    logic stretch_active;

    pulse_stretch #(
        .CYCLES(PULSE_CYCLES)
    ) u_stretch (
        .ref_clk(ref_clk),
        .rst(rst),
        .trigger(any_src),
        .active(stretch_active)
    );

    logic sys_n_r;
    logic sys_n_nxt;

    // Release only after stretch ends, one register stage keeps it glitch-free
    always_comb begin
        sys_n_nxt = !stretch_active;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sys_n_r <= 1'b0;
        end else begin
            sys_n_r <= sys_n_nxt;
        end
    end

    assign sys_reset_n = sys_n_r;

    assign core_reset_n = sys_n_r;
    assign periph_reset_n = sys_n_r;
    // Debug port follows only the cold reset, so a debugger survives system resets
    assign debug_port_reset_n = cold_n_r;

    // ----------------------------------------
    // Backup domain reset
    // ----------------------------------------
    logic bkp_n_r;
    logic bkp_n_nxt;

    always_comb begin
        bkp_n_nxt = !(bkp_bit_s || bkp_pon_s);
    end

    // Limitation: the backup domain shares this clock here, so it is reset by rst as well
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bkp_n_r <= 1'b0;
        end else begin
            bkp_n_r <= bkp_n_nxt;
        end
    end

    assign backup_reset_n = bkp_n_r;
endmodule

// ### tb/rcu_props.sv
// Checker for the reset control unit outputs
`timescale 1ns/10ps
module rcu_props
    import reset_ctl_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = SYS_PULSE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic supply_up_down_detect,
    input wire logic regulator_ready,
    input wire logic ext_reset_pin_n,
    input wire reset_req_t reset_req,
    input wire reset_en_t reset_en,
    input wire logic standby_entry,
    input wire logic standby_entry_reset_opt,
    input wire logic backup_domain_reset_bit,
    input wire logic cold_reset_n,
    input wire logic sys_reset_n,
    input wire logic core_reset_n,
    input wire logic periph_reset_n,
    input wire logic debug_port_reset_n,
    input wire logic backup_reset_n,
    input wire logic standby_entry_reset_n
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    logic [15:0] low_cnt_r;
    // Low cycles of the system reset, saturating so it never wraps
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            low_cnt_r <= 16'h0000;
        else if (sys_reset_n)
            low_cnt_r <= 16'h0000;
        else if (low_cnt_r != 16'hffff)
            low_cnt_r <= low_cnt_r + 16'h0001;
    end
    AST_DBG: assert property (debug_port_reset_n == cold_reset_n)
        else $error("debug port reset differs from cold reset");
    AST_CORE: assert property (core_reset_n == sys_reset_n && periph_reset_n == sys_reset_n)
        else $error("core or peripheral reset differs from system reset");
    AST_COLD: assert property (supply_up_down_detect |-> ##[1:4] !cold_reset_n)
        else $error("supply detector did not give cold reset");
    AST_REG: assert property (!regulator_ready |-> ##[1:4] !cold_reset_n)
        else $error("cold reset released before rail ready");
    AST_COLD_SYS: assert property (!cold_reset_n |-> ##[0:4] !sys_reset_n)
        else $error("cold reset without system reset");
    AST_PIN: assert property (!ext_reset_pin_n |-> ##[1:4] !sys_reset_n)
        else $error("pin reset missed");
    AST_REQ: assert property (!(&reset_req[8:5]) |-> ##[1:4] !sys_reset_n)
        else $error("watchdog, soft or loader reset missed");
    AST_EN: assert property ((~reset_req[4:0] & reset_en) != 5'h00 |-> ##[1:4] !sys_reset_n)
        else $error("enabled fault reset missed");
    AST_STRETCH: assert property ($rose(sys_reset_n) |-> low_cnt_r >= PULSE_CYCLES)
        else $error("system reset pulse too short");
    AST_STBY: assert property (standby_entry && !standby_entry_reset_opt |-> ##[1:4] !standby_entry_reset_n)
        else $error("standby entry reset missed");
    AST_BKP: assert property (backup_domain_reset_bit |-> ##[1:4] !backup_reset_n)
        else $error("backup reset bit ignored");
    AST_BKP_SPARE: assert property ($fell(sys_reset_n) |-> backup_reset_n)
        else $error("system reset hit backup domain");
    cover property ($rose(sys_reset_n));
    cover property ($fell(backup_reset_n));
    cover property ($fell(standby_entry_reset_n));
endmodule
bind reset_control_unit rcu_props #(.PULSE_CYCLES(PULSE_CYCLES)) props_i (.*);

// ### tb/regulator_model.sv
// Core regulator model: rail ready a fixed time after cold sources clear
`timescale 1ns/10ps
module regulator_model #(
    parameter int unsigned DELAY = 20
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic supply_up_down_detect,
    input wire logic standby_exit,
    output logic regulator_ready
);
    // ----
    // Rail
    // ----
    int unsigned cnt_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            cnt_r <= '0;
        else if (supply_up_down_detect || standby_exit)
            cnt_r <= '0;
        else if (cnt_r < DELAY)
            cnt_r <= cnt_r + 1;
    end
    assign regulator_ready = (cnt_r == DELAY);
endmodule

// ### tb/tb_reset_control_unit.sv
// Self-checking bench for the reset control unit
`timescale 1ns/10ps
module tb_reset_control_unit
    import reset_ctl_pkg::*;
;
    // ----
    // Bench
    // ----
    localparam int unsigned PC = 8;
    logic ref_clk = 1'h0, rst = 1'h1, supply_up_down_detect = 1'h0, standby_exit = 1'h0;
    logic ext_reset_pin_n = 1'h1, standby_entry = 1'h0, deepsleep_entry = 1'h0;
    logic standby_entry_reset_opt = 1'h1, deepsleep_entry_reset_opt = 1'h1;
    logic backup_domain_reset_bit = 1'h0, backup_supply_power_on = 1'h0, regulator_ready;
    reset_req_t reset_req = '1;
    reset_en_t reset_en = '1;
    logic cold_reset_n, sys_reset_n, core_reset_n, periph_reset_n;
    logic debug_port_reset_n, backup_reset_n, standby_entry_reset_n, deepsleep_entry_reset_n;
    int n_fail = 0, checks_done = 0, cyc = 0;
    reset_control_unit #(.PULSE_CYCLES(PC)) uut (.*);
    regulator_model rail_i (.*);
    // Short pulse count keeps the run brief
    initial forever #10 ref_clk = ~ref_clk;
    task automatic wrap_up;
        $display("fails %0d checks %0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            wrap_up;
        end
    end
    task automatic chk(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Wait for system reset release, counting low cycles
    task automatic rel(input int lo);
        int n;
        n = 0;
        while (sys_reset_n !== 1'h1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n >= lo, 1'h1);
        chk(sys_reset_n, 1'h1);
    endtask
    task automatic cold(input int k);
        int n;
        @(posedge ref_clk);
        supply_up_down_detect <= (k == 1);
        standby_exit <= (k == 2);
        step(2);
        supply_up_down_detect <= 1'h0;
        standby_exit <= 1'h0;
        step(4);
        @(negedge ref_clk);
        chk(cold_reset_n, 1'h0);
        chk(debug_port_reset_n, 1'h0);
        chk(sys_reset_n, 1'h0);
        n = 0;
        while (cold_reset_n !== 1'h1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        chk(regulator_ready, 1'h1);
        rel(PC);
    endtask
    task automatic srcs;
        int w;
        for (int k = 0; k < 10; k++) begin
            @(posedge ref_clk);
            if (k < REQ_W)
                reset_req[k] <= 1'h0;
            else
                ext_reset_pin_n <= 1'h0;
            @(posedge ref_clk);
            reset_req <= '1;
            ext_reset_pin_n <= 1'h1;
            w = 0;
            // Catch the fall itself, so the whole low pulse is counted
            while (sys_reset_n !== 1'h0 && w < 4) begin
                @(negedge ref_clk);
                w++;
            end
            chk(sys_reset_n, 1'h0);
            chk(core_reset_n | periph_reset_n, 1'h0);
            chk(debug_port_reset_n & backup_reset_n, 1'h1);
            rel(PC);
        end
    endtask
    task automatic mask;
        @(posedge ref_clk);
        reset_en <= '0;
        for (int k = 0; k < 5; k++) begin
            @(posedge ref_clk);
            reset_req[k] <= 1'h0;
            repeat (8) begin
                @(negedge ref_clk);
                chk(sys_reset_n, 1'h1);
            end
            @(posedge ref_clk);
            reset_req <= '1;
        end
        step(4);
        reset_en <= '1;
    endtask
    task automatic entry(input bit dp);
        @(posedge ref_clk);
        {deepsleep_entry, standby_entry} <= dp ? 2'h2 : 2'h1;
        step(5);
        @(negedge ref_clk);
        chk(dp ? deepsleep_entry_reset_n : standby_entry_reset_n, 1'h1);
        @(posedge ref_clk);
        {deepsleep_entry_reset_opt, standby_entry_reset_opt} <= dp ? 2'h1 : 2'h2;
        step(5);
        @(negedge ref_clk);
        chk(dp ? deepsleep_entry_reset_n : standby_entry_reset_n, 1'h0);
        @(posedge ref_clk);
        {deepsleep_entry, standby_entry} <= 2'h0;
        {deepsleep_entry_reset_opt, standby_entry_reset_opt} <= 2'h3;
        step(5);
        @(negedge ref_clk);
        chk(dp ? deepsleep_entry_reset_n : standby_entry_reset_n, 1'h1);
        // Entry reset cleared two cycles before this point, the rest must still follow
        rel(PC - 2);
    endtask
    task automatic bkp(input bit pw);
        @(posedge ref_clk);
        {backup_supply_power_on, backup_domain_reset_bit} <= pw ? 2'h2 : 2'h1;
        step(5);
        @(negedge ref_clk);
        chk(backup_reset_n, 1'h0);
        @(posedge ref_clk);
        {backup_supply_power_on, backup_domain_reset_bit} <= 2'h0;
        step(5);
        @(negedge ref_clk);
        chk(backup_reset_n, 1'h1);
    endtask
    initial begin
        step(5);
        rst <= 1'h0;
        for (int k = 0; k < 3; k++)
            cold(k);
        srcs;
        mask;
        entry(1'b0);
        entry(1'b1);
        bkp(1'b0);
        bkp(1'b1);
        wrap_up;
    end
endmodule
